// *** verilog/link_error_monitor.sv ***
// Purpose: Per-port error and status monitor for four camera link inputs, read over APB.
// Assumes: Link events are levels sampled at rising edges of link_clk, found by pclk.
// Notes: All link inputs pass two flip-flops; one pclk domain.
`timescale 1ns/10ps
`include "link_mon_defs.svh"

module link_error_monitor #(
	parameter int CTRL_ACK_CYCLES = `CTRL_ACK_CYC,
	parameter int TRIG_PKT_TICKS = `TRIG_PKT_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic link_clk,
	input wire logic [3:0] code_err,
	input wire logic [3:0] disp_err,
	input wire logic [3:0] cdr_locked,
	input wire logic [3:0] sym_valid,
	input wire logic [3:0] stream_incomplete,
	input wire logic [3:0] unknown_pkt,
	input wire logic [3:0] trig_req,
	input wire logic [3:0] trig_ack,
	input wire logic [3:0] ctrl_sent,
	input wire logic [3:0] ctrl_ack,
	output logic [3:0] trig_busy
);
	import link_mon_pkg::*;

	localparam int NIN = 10;
	localparam logic [5:0] TRIG_SLOW = 6'(`TRIG_ACK_SLOW_CYC);
	localparam logic [5:0] TRIG_FAST = 6'(`TRIG_ACK_FAST_CYC);
	localparam logic [24:0] CTRL_LIM = 25'(CTRL_ACK_CYCLES);
	localparam logic [3:0] PKT_LIM = 4'(TRIG_PKT_TICKS);

	// Register map, one aligned 32-bit word per register, byte addresses:
	//   0x00 control: bit 0 selects the short acknowledgment window of the fast link rates.
	//   0x04 channel map: bits 2i+1:2i hold the firmware channel that port i watches.
	//   0x08 port select: the index of the port whose per-port values are read.
	//   0x0c firmware channel of the selected port.
	//   0x10 symbol code error count of the selected port, bits 31:0.
	//   0x14 symbol code error count of the selected port, bits 47:32.
	//   0x18 alignment lock flag of the selected port.
	//   0x1c incomplete stream count of the selected port.
	//   0x20 unknown packet count of the selected port.
	//   0x24 skipped trigger count of the selected port.
	//   0x28 trigger acknowledgment timeout count of the selected port.
	//   0x2c control acknowledgment timeout count of the selected port.
	//   0x30 sticky event status, read only.
	//   0x34 event enable, same layout as the status.
	//   0x38 event clear, write ones to clear, reads as zero.
	// Status layout, one bit per port in each group of four:
	//   bits 3:0 symbol errors, bits 7:4 incomplete streams, bits 11:8 unknown packets,
	//   bits 15:12 skipped triggers, bits 19:16 trigger acknowledgment timeouts,
	//   bits 23:20 control acknowledgment timeouts, bits 27:24 loss of lock.
	// The two halves of the symbol count are not latched together, so software that
	// reads them while errors arrive must read again if the high half changed.
	// Any other address answers with a slave error and changes nothing.

	// Wrapping 12-bit counter in bits 11:0 whose overflow bit 12, once set, stays set.
	function automatic cnt13_t bump13(input cnt13_t c);
		bump13 = {c[12] | (&c[11:0]), c[11:0] + 12'h001};
	endfunction

	// Link clock and inputs; the first stage feeds only the second.
	// The link clock is slow against pclk, so its rising edges are found from the
	// synchronised copy and every event input is sampled at the same stage.
	// An event input that stays high over one link edge counts exactly once.
	// The inputs are grouped so that bit 4*k+c is input kind k of firmware channel c.
	logic link_m_r, link_s_r, link_d_r;
	logic [4*NIN-1:0] in_m_r, in_s_r;
	wire [4*NIN-1:0] in_raw = {ctrl_ack, ctrl_sent, trig_ack, trig_req, unknown_pkt,
		stream_incomplete, sym_valid, cdr_locked, disp_err, code_err};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_m_r <= 1'b0;
			link_s_r <= 1'b0;
			link_d_r <= 1'b0;
			in_m_r <= '0;
			in_s_r <= '0;
		end else begin
			link_m_r <= link_clk;
			link_s_r <= link_m_r;
			link_d_r <= link_s_r;
			in_m_r <= in_raw;
			in_s_r <= in_m_r;
		end
	end
	wire link_tick = link_s_r & ~link_d_r;

	// Register state.
	logic fast_r;
	logic [7:0] map_r;
	port_idx_t sel_r;
	logic [`STAT_WIDTH-1:0] stat_r, en_r;
	logic [`STAT_WIDTH-1:0] stat_set;

	wire access = psel & penable;
	wire wr_en = access & pwrite & pready;

	// Write decode; a write lands only at the edge on which pready is high.
	wire wr_ctrl = wr_en && (paddr == `OFS_CTRL);
	wire wr_map = wr_en && (paddr == `OFS_MAP);
	wire wr_sel = wr_en && (paddr == `OFS_SEL);
	wire wr_irq_en = wr_en && (paddr == `OFS_IRQ_ENABLE);

	wire [`STAT_WIDTH-1:0] stat_clr = (wr_en && paddr == `OFS_IRQ_CLEAR) ?
		pwdata[`STAT_WIDTH-1:0] : '0;

	logic [47:0] sym_cnt [4];
	logic lock_flag [4];
	cnt13_t inc_cnt [4], unk_cnt [4], skip_cnt [4], ttmo_cnt [4], ctmo_cnt [4];
	logic [3:0] trig_busy_nxt;

	// Each port below is a full copy of the per-port monitor logic. The trigger sender of a port
	// goes through three states:
	//   idle: a trigger request starts a packet;
	//   send: the packet takes TRIG_PKT_TICKS link ticks, requests in it are dropped;
	//   wait: the acknowledgment window runs in pclk cycles; a new request starts
	//         another packet, an acknowledgment or the end of the window goes idle.
	// The window length is rounded down to whole pclk cycles, so at other pclk rates
	// a timeout may be reported up to one cycle early.
	// The control acknowledgment window is counted in pclk cycles as well and is
	// restarted by every control packet sent before the previous one was answered.

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : port
			// The monitored firmware channel steers which inputs this port watches.
			wire [1:0] ch = map_r[2*g +: 2];
			wire [NIN-1:0] ev;
			genvar k;
			for (k = 0; k < NIN; k++) begin : pick
				assign ev[k] = in_s_r[4*k + ch];
			end

			// Events are qualified by the link tick; the lock flag follows the level.
			wire sample = link_tick;
			wire sym_ev = sample & (ev[0] | ev[1]);
			wire lock_now = ev[2] & ev[3];
			wire inc_ev = sample & ev[4];
			wire unk_ev = sample & ev[5];
			wire req_ev = sample & ev[6];
			wire tack_ev = sample & ev[7];
			wire csent_ev = sample & ev[8];
			wire cack_ev = sample & ev[9];

			logic [47:0] sym_r;
			logic lock_r;
			cnt13_t inc_r, unk_r, skip_r, ttmo_r, ctmo_r;
			trig_state_t st_r, st_nxt;
			logic [3:0] pkt_r;
			logic [5:0] tack_r;
			logic busy_r;
			logic cwait_r;
			logic [24:0] cack_r;

			// Trigger sender and its acknowledgment window.
			wire pkt_done = (st_r == TX_SEND) && sample && (pkt_r == PKT_LIM - 4'h1);
			wire [5:0] tack_lim = fast_r ? TRIG_FAST : TRIG_SLOW;
			wire tack_tmo = (st_r == TX_WAIT) && !tack_ev && (tack_r == tack_lim - 6'h01);
			wire skip_ev = req_ev && (st_r == TX_SEND);

			// A new control packet in the expiry cycle restarts the window instead.
			wire ctmo_ev = cwait_r && !cack_ev && !csent_ev && (cack_r == CTRL_LIM - 25'h1);

			always_comb begin
				st_nxt = st_r;
				unique case (st_r)
					TX_IDLE: begin
						if (req_ev) st_nxt = TX_SEND;
					end
					TX_SEND: begin
						if (pkt_done) st_nxt = TX_WAIT;
					end
					TX_WAIT: begin
						if (req_ev) st_nxt = TX_SEND;
						else if (tack_ev || tack_tmo) st_nxt = TX_IDLE;
					end
					default: st_nxt = TX_IDLE;
				endcase
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_r <= TX_IDLE;
					busy_r <= 1'b0;
					pkt_r <= 4'h0;
					tack_r <= 6'h00;
				end else begin
					st_r <= st_nxt;
					busy_r <= (st_nxt == TX_SEND);
					if (st_r != TX_SEND) pkt_r <= 4'h0;
					else if (sample) pkt_r <= pkt_r + 4'h1;
					// The acknowledgment window opens when the packet has gone out.
					if (st_r != TX_WAIT) tack_r <= 6'h00;
					else tack_r <= tack_r + 6'h01;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cwait_r <= 1'b0;
					cack_r <= 25'h0;
				end else if (csent_ev) begin
					cwait_r <= 1'b1;
					cack_r <= 25'h0;
				end else if (cack_ev || ctmo_ev) begin
					cwait_r <= 1'b0;
					cack_r <= 25'h0;
				end else if (cwait_r) begin
					cack_r <= cack_r + 25'h1;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sym_r <= 48'h0;
					lock_r <= 1'b0;
					inc_r <= '0;
					unk_r <= '0;
					skip_r <= '0;
					ttmo_r <= '0;
					ctmo_r <= '0;
				end else begin
					if (sym_ev) sym_r <= sym_r + 48'h1;
					lock_r <= lock_now;
					if (inc_ev) inc_r <= inc_r + 13'h0001;
					if (unk_ev) unk_r <= unk_r + 13'h0001;
					if (skip_ev) skip_r <= bump13(skip_r);
					if (tack_tmo) ttmo_r <= bump13(ttmo_r);
					if (ctmo_ev) ctmo_r <= bump13(ctmo_r);
				end
			end

			// Hand the per-port values to the read mux and the trig_busy output register.
			assign sym_cnt[g] = sym_r;
			assign lock_flag[g] = lock_r;
			assign inc_cnt[g] = inc_r;
			assign unk_cnt[g] = unk_r;
			assign skip_cnt[g] = skip_r;
			assign ttmo_cnt[g] = ttmo_r;
			assign ctmo_cnt[g] = ctmo_r;
			assign trig_busy_nxt[g] = busy_r;

			// Status set terms; loss of lock is the falling edge of the lock flag.
			assign stat_set[`STAT_SYM_LSB + g] = sym_ev;
			assign stat_set[`STAT_INC_LSB + g] = inc_ev;
			assign stat_set[`STAT_UNK_LSB + g] = unk_ev;
			assign stat_set[`STAT_SKIP_LSB + g] = skip_ev;
			assign stat_set[`STAT_TTMO_LSB + g] = tack_tmo;
			assign stat_set[`STAT_CTMO_LSB + g] = ctmo_ev;
			assign stat_set[`STAT_LOCK_LSB + g] = lock_r & ~lock_now;
		end
	endgenerate

	// Read decode; the selected port index picks one instance of each value.
	wire [47:0] sym_sel = sym_cnt[sel_r];
	logic [31:0] rd_mux;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0;
		unique case (paddr)
			`OFS_CTRL: rd_mux = {31'h0, fast_r};
			`OFS_MAP: rd_mux = {24'h0, map_r};
			`OFS_SEL: rd_mux = {30'h0, sel_r};
			`OFS_FW_MAP: rd_mux = {30'h0, map_r[2*sel_r +: 2]};
			`OFS_SYM_LO: rd_mux = sym_sel[31:0];
			`OFS_SYM_HI: rd_mux = {16'h0, sym_sel[47:32]};
			`OFS_LOCK: rd_mux = {31'h0, lock_flag[sel_r]};
			`OFS_INCOMPLETE: rd_mux = {19'h0, inc_cnt[sel_r]};
			`OFS_UNKNOWN: rd_mux = {19'h0, unk_cnt[sel_r]};
			`OFS_SKIPPED: rd_mux = {19'h0, skip_cnt[sel_r]};
			`OFS_TRIG_TMO: rd_mux = {19'h0, ttmo_cnt[sel_r]};
			`OFS_CTRL_TMO: rd_mux = {19'h0, ctmo_cnt[sel_r]};
			`OFS_IRQ_STATUS: rd_mux = {{(32-`STAT_WIDTH){1'b0}}, stat_r};
			`OFS_IRQ_ENABLE: rd_mux = {{(32-`STAT_WIDTH){1'b0}}, en_r};
			`OFS_IRQ_CLEAR: rd_mux = 32'h0;
			default: rd_hit = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle, so reads see settled counters.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= access & ~pready;
			prdata <= (access && !pready && !pwrite && rd_hit) ? rd_mux : 32'h0;
			pslverr <= access & ~pready & ~rd_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_r <= 1'b0;
			map_r <= `MAP_RESET;
			sel_r <= 2'h0;
			en_r <= '0;
		end else begin
			if (wr_ctrl) fast_r <= pwdata[`CTRL_FAST_BIT];
			if (wr_map) map_r <= pwdata[7:0];
			if (wr_sel) sel_r <= pwdata[1:0];
			if (wr_irq_en) en_r <= pwdata[`STAT_WIDTH-1:0];
		end
	end

	// A new event in the clearing cycle keeps its bit set.
	// The interrupt is computed from the next status so it changes in the same cycle as status,
	// and the busy flags are registered here so every top output leaves a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
			irq <= 1'b0;
			trig_busy <= 4'h0;
		end else begin
			stat_r <= (stat_r & ~stat_clr) | stat_set;
			irq <= |(((stat_r & ~stat_clr) | stat_set) & en_r);
			trig_busy <= trig_busy_nxt;
		end
	end
endmodule // link_error_monitor

// *** verilog/link_mon_defs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the link monitor.
// Assumes: pclk at 100 MHz, APB with 32-bit data.
// Notes: Definitions only.
`ifndef LINK_MON_DEFS_SVH
`define LINK_MON_DEFS_SVH

`define CLK_PERIOD_NS 10
`define TRIG_ACK_SLOW_NS 480
`define TRIG_ACK_FAST_NS 240
`define CTRL_ACK_MS 200
// Longest times round down to whole cycles; the trigger windows never go below one.
`define TRIG_ACK_SLOW_CYC (((`TRIG_ACK_SLOW_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`TRIG_ACK_SLOW_NS / `CLK_PERIOD_NS))
`define TRIG_ACK_FAST_CYC (((`TRIG_ACK_FAST_NS / `CLK_PERIOD_NS) < 1) ? 1 : (`TRIG_ACK_FAST_NS / `CLK_PERIOD_NS))
`define CTRL_ACK_CYC ((`CTRL_ACK_MS * 1000000) / `CLK_PERIOD_NS)
`define TRIG_PKT_TICKS 4

`define OFS_CTRL 8'h00
`define OFS_MAP 8'h04
`define OFS_SEL 8'h08
`define OFS_FW_MAP 8'h0c
`define OFS_SYM_LO 8'h10
`define OFS_SYM_HI 8'h14
`define OFS_LOCK 8'h18
`define OFS_INCOMPLETE 8'h1c
`define OFS_UNKNOWN 8'h20
`define OFS_SKIPPED 8'h24
`define OFS_TRIG_TMO 8'h28
`define OFS_CTRL_TMO 8'h2c
`define OFS_IRQ_STATUS 8'h30
`define OFS_IRQ_ENABLE 8'h34
`define OFS_IRQ_CLEAR 8'h38

`define CTRL_FAST_BIT 0
`define MAP_RESET 8'he4
`define STAT_SYM_LSB 0
`define STAT_INC_LSB 4
`define STAT_UNK_LSB 8
`define STAT_SKIP_LSB 12
`define STAT_TTMO_LSB 16
`define STAT_CTMO_LSB 20
`define STAT_LOCK_LSB 24
`define STAT_WIDTH 28

`endif

// *** verilog/link_mon_pkg.sv ***
// Purpose: Types shared by the link monitor.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Offsets and counts live in link_mon_defs.svh.
package link_mon_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01,
		TX_WAIT = 2'b10
	} trig_state_t;
	typedef logic [12:0] cnt13_t;
	typedef logic [1:0] port_idx_t;
endpackage

// *** verification/link_mon_checker.sv ***
// Purpose: Port assertions for the link monitor.
// Assumes: 10 ns pclk, 80 ns link clock.
// Notes: Bound into every link_error_monitor.
`timescale 1ns/10ps
module link_mon_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic [3:0] trig_busy
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("pready held");
	property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
	a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
	property p_rdy_cause; pready |-> $past(psel && penable); endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("pready uncaused");
	property p_err_map; pready && paddr > 8'h38 |-> pslverr; endproperty
	a_err_map: assert property (p_err_map) else $error("no slave error");
	property p_err_rd0; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err_rd0: assert property (p_err_rd0) else $error("bad error answer");
	// A trigger packet lasts four link ticks, eight pclk each.
	property p_busy_len; $rose(|trig_busy) |-> (|trig_busy) [*8]; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy too short");
	property p_busy_end; $rose(|trig_busy) |-> ##[24:40] $fell(|trig_busy); endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy wrong length");
	property p_irq_off; pready && pwrite && paddr == 8'h34 && pwdata[27:0] == 28'h0
		|-> ##2 !irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq not masked");
endmodule // link_mon_checker

bind link_error_monitor link_mon_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .trig_busy);

// *** verification/camera_link_model.sv ***
// Purpose: Camera side of the link: link clock and trigger acknowledgments.
// Assumes: Trigger packet end is seen as a fall of trig_busy.
// Notes: Acks go to all channels, so port order does not matter.
`timescale 1ns/10ps
module camera_link_model (
	input wire logic en,
	input wire logic ack_on,
	input wire logic [3:0] trig_busy,
	output logic link_clk,
	output logic [3:0] trig_ack
);
	logic [3:0] busy_r;
	// The 3 ns offset keeps link edges away from pclk edges.
	initial begin
		link_clk = 1'b0;
		trig_ack = 4'h0;
		busy_r = 4'h0;
		#3;
		forever #40 link_clk = en ? ~link_clk : 1'b0;
	end
	always @(posedge link_clk) begin
		busy_r <= trig_busy;
		trig_ack <= ack_on ? {4{|(busy_r & ~trig_busy)}} : 4'h0;
	end
endmodule // camera_link_model

// *** verification/link_error_monitor_tb.sv ***
// Purpose: Self-checking bench for link_error_monitor.
// Assumes: The partner model makes the link clock.
// Notes: Reads are scored against a queue of expected values.
`timescale 1ns/10ps
module link_error_monitor_tb;
	import link_mon_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, link_clk, en, ack_on;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] ev [9];
	logic [3:0] trig_ack, trig_busy, vm;
	logic [31:0] q_d [$];
	int errors, comparisons, r, k, p, mw;
	int cnt [3][4];
	link_error_monitor #(.CTRL_ACK_CYCLES(50), .TRIG_PKT_TICKS(4)) DUT (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .link_clk,
		.code_err(ev[0]), .disp_err(ev[1]), .stream_incomplete(ev[2]), .unknown_pkt(ev[3]),
		.trig_req(ev[4]), .ctrl_sent(ev[5]), .ctrl_ack(ev[6]), .cdr_locked(ev[7]),
		.sym_valid(ev[8]), .trig_ack, .trig_busy);
	camera_link_model partner (.en, .ack_on, .trig_busy, .link_clk, .trig_ack);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report;
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			check($sformatf("read %h", paddr), q_d.pop_front(), prdata);
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			final_report;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q_d.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// Eight pclk cover exactly one link edge, so one pulse is one event.
	task automatic pulse(input int kind, input int port);
		ev[kind] <= 4'h1 << ((port + r) & 3);
		repeat (8) @(posedge pclk);
		ev[kind] <= 4'h0;
		repeat (8) @(posedge pclk);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		en = 1'b1;
		ack_on = 1'b1;
		foreach (ev[i]) ev[i] = 4'h0;
		cnt = '{default: 0};
		errors = 0;
		comparisons = 0;
		void'($urandom(32'h20a4));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (p = 0; p < 4; p++) begin
			apb(1'b1, 8'h08, p);
			rd(8'h0c, p);
		end
		r = $urandom_range(3);
		mw = 0;
		for (p = 0; p < 4; p++) mw |= ((p + r) & 3) << (2 * p);
		apb(1'b1, 8'h04, mw);
		apb(1'b1, 8'h34, 32'h00ffffff);
		vm = $urandom;
		ev[7] <= 4'hf;
		ev[8] <= vm;
		repeat (12) begin
			k = $urandom_range(3);
			p = $urandom_range(3);
			pulse(k, p);
			cnt[k < 2 ? 0 : k - 1][p]++;
		end
		check("irq", 1, irq);
		for (p = 0; p < 4; p++) begin
			apb(1'b1, 8'h08, p);
			rd(8'h0c, (p + r) & 3);
			rd(8'h10, cnt[0][p]);
			rd(8'h14, 0);
			rd(8'h18, vm[(p + r) & 3]);
			rd(8'h1c, cnt[1][p]);
			rd(8'h20, cnt[2][p]);
		end
		apb(1'b1, 8'h08, 0);
		pulse(4, 0);
		pulse(4, 0);
		repeat (100) @(posedge pclk);
		ack_on <= 1'b0;
		pulse(4, 0);
		repeat (100) @(posedge pclk);
		apb(1'b1, 8'h00, 1);
		pulse(4, 0);
		repeat (100) @(posedge pclk);
		rd(8'h24, 1);
		rd(8'h28, 2);
		pulse(5, 0);
		repeat (80) @(posedge pclk);
		pulse(5, 0);
		pulse(6, 0);
		repeat (80) @(posedge pclk);
		rd(8'h2c, 1);
		apb(1'b1, 8'h38, 32'h0fffffff);
		repeat (2) @(posedge pclk);
		check("irq", 0, irq);
		rd(8'h3c, 0);
		apb(1'b1, 8'h34, 0);
		final_report;
	end
endmodule // link_error_monitor_tb
